// ===== inc/mirl_pkg.sv
/*
 Constants, types and register map of the interrupt request logic.
 Assumes one 20 MHz clock domain and an AXI4-Lite register bus.
*/
package mirl_pkg;

    // ------------------------------------------------------------
    // Register map (index times four is the byte address)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_INT_STATUS = 6'h00;
    localparam logic [5:0] IDX_EXT_INT_STATUS_CONTROL = 6'h0A;
    localparam logic [5:0] IDX_OPTION_REGISTER = 6'h17;

    // Field positions
    localparam int EXT_INT_ENABLE_BIT = 7;
    localparam int EXT_INT_PENDING_FLAG_BIT = 3;
    localparam int EXT_INT_FLAG_CLEAR_BIT = 1;
    localparam int PORTA_INT_OPTION_BIT = 2;
    localparam int LEVEL_SENSE_BIT = 1;

    // Own status register fields
    localparam int STAT_MASK_BIT = 0;
    localparam int STAT_EXT_REQ_BIT = 1;
    localparam int STAT_TIMER_REQ_BIT = 2;
    localparam int STAT_SEQ_LSB = 4;
    localparam int STAT_SRC_LSB = 6;

    // Reset values
    localparam logic EXT_INT_ENABLE_RESET = 1'b1;
    localparam logic GLOBAL_MASK_RESET = 1'b1;
    localparam logic LEVEL_SENSE_RESET = 1'b0;
    localparam logic PORTA_INT_OPTION_RESET = 1'b0;

    // Vector locations
    localparam logic [15:0] VEC_SOFT_TRAP = 16'h03FC;
    localparam logic [15:0] VEC_EXTERNAL = 16'h03FA;
    localparam logic [15:0] VEC_TIMER = 16'h03F8;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_STACK = 2'b01,
        SEQ_FETCH = 2'b10
    } mirl_seq_t;

    typedef enum logic [1:0] {
        SRC_SOFT_TRAP = 2'b00,
        SRC_EXTERNAL = 2'b01,
        SRC_TIMER = 2'b10
    } mirl_src_t;

    // Timer flags and their enables
    typedef struct packed {
        logic timer_overflow_flag;
        logic timer_overflow_int_en;
        logic periodic_int_flag;
        logic periodic_int_en;
    } mirl_timer_t;

endpackage : mirl_pkg

// ===== rtl/mirl_core.sv
/*
 Interrupt request logic: external pin and port pin latching,
 timer request forming, global mask, entry sequencing toward the
 CPU sequencer and an AXI4-Lite register slave.
 Assumes the CPU sequencer pulses instr_done at each instruction
 boundary and answers stack_req and vector_valid with acks.
*/
// Design decision made here: the AXI4-Lite register port.

// What this block does
// - Take interrupts only at instruction boundaries, never mid-instruction.
// - Entry requests register stacking, then presents the source vector.
// - Soft trap instruction interrupts regardless of mask or enables.
// - External requests blocked by global mask set or enable clear.
// - At boundary, start entry when latch and enable set, mask clear.
// - Clear the external latch during vector fetch, allowing new capture.
// - Level sense: falling edge or low pin latches and keeps request.
// - Edge sense: only falling edges latch; re-arm needs pin high first.
// - Port option makes four low port pins extra external sources.
// - Port pin high/rising latches only if others low, ext pin high.
// - With port option, ext pin triggers only while all port pins low.
// - Level sense with ports: request present while port high or pin low.
// - Edge sense: port re-request needs its signal to fall and rise.
// - Status/control: enable bit 7, pending bit 3, clear bit 1, others zero.
// - Enable bit is read/write, set by reset, allows external processing.
// - Pending flag read-only, set by pin or port requests, reset clears.
// - Pending flag cleared at external vector fetch; direct writes ignored.
// - Writing one to clear bit clears pending; zero no effect.
// - Global mask blocks timer overflow and periodic requests.
// - Overflow flag with its enable raises a timer request.
// - Periodic flag with its enable raises a timer request.
// - Entry sets global mask and loads trap, external or timer vector.
// - Several pending: external outranks timer, highest vector first.
module mirl_core (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Request pins
    input wire logic ext_int_pin_n,
    input wire logic [3:0] port_a_low_pins,
    // Timer flags and enables
    input wire mirl_pkg::mirl_timer_t timer_in,
    // CPU sequencer side
    input wire logic instr_done,
    input wire logic soft_trap_instr,
    input wire logic mask_clear,
    input wire logic stack_ack,
    input wire logic vector_ack,
    output logic stack_req,
    output logic vector_valid,
    output logic [15:0] vector_addr,
    output logic global_mask,
    output logic ext_int_pending_flag,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic irq_meta;
    logic irq_sync;
    logic irq_prev;
    logic [3:0] pa_meta;
    logic [3:0] pa_sync;
    logic [3:0] pa_prev;
    logic ext_int_enable;
    logic level_sense;
    logic porta_int_option;
    logic irq_trig;
    logic [3:0] pa_trig;
    logic ext_set;
    logic ext_clear;
    logic level_hold;
    logic ext_req;
    logic timer_req;
    logic wr_fire;
    logic [5:0] aw_idx;
    logic [31:0] aw_data;
    logic [3:0] aw_strb;
    logic wr_ext_int_status_control;
    logic wr_option;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    mirl_pkg::mirl_seq_t seq;
    mirl_pkg::mirl_src_t src;

    // ------------------------------------------------------------
    // Pin synchronisers and edge history
    // ------------------------------------------------------------

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_meta <= 1'b1;
            irq_sync <= 1'b1;
            irq_prev <= 1'b1;
            pa_meta <= 4'h0;
            pa_sync <= 4'h0;
            pa_prev <= 4'h0;
        end else begin
            irq_meta <= ext_int_pin_n;
            irq_sync <= irq_meta;
            irq_prev <= irq_sync;
            pa_meta <= port_a_low_pins;
            pa_sync <= pa_meta;
            pa_prev <= pa_sync;
        end
    end

    // ------------------------------------------------------------
    // External request triggers
    // ------------------------------------------------------------

    // pin trigger, gated by port pins when enabled
    assign irq_trig = (level_sense ? ~irq_sync : (irq_prev & ~irq_sync))
                      & (~porta_int_option | ~(|pa_sync));

    // Per-pin port triggers
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_port
            // port pin trigger, others low and pin high
            assign pa_trig[gi] = porta_int_option
                & (level_sense ? pa_sync[gi] : (pa_sync[gi] & ~pa_prev[gi]))
                & ~(|(pa_sync & ~(4'h1 << gi)))
                & irq_sync;
        end
    endgenerate

    assign ext_set = irq_trig | (|pa_trig);

    // level sources keep the request present
    assign level_hold = level_sense & (~irq_sync | (porta_int_option & (|pa_sync)));

    // clear at external fetch or by software strobe
    assign ext_clear = (seq == mirl_pkg::SEQ_FETCH && vector_ack && src == mirl_pkg::SRC_EXTERNAL)
                       | (wr_ext_int_status_control & aw_data[mirl_pkg::EXT_INT_FLAG_CLEAR_BIT]);

    // enable and mask gate the external request
    assign ext_req = (ext_int_pending_flag | level_hold) & ext_int_enable & ~global_mask;

    assign timer_req = ~global_mask
        & ((timer_in.timer_overflow_flag & timer_in.timer_overflow_int_en)
        | (timer_in.periodic_int_flag & timer_in.periodic_int_en));

    // Pending latch, a set in the clearing cycle wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_int_pending_flag <= 1'b0;
        end else if (ext_set) begin
            ext_int_pending_flag <= 1'b1;
        end else if (ext_clear) begin
            ext_int_pending_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Entry sequencer
    // ------------------------------------------------------------

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seq <= mirl_pkg::SEQ_IDLE;
            src <= mirl_pkg::SRC_SOFT_TRAP;
            stack_req <= 1'b0;
            vector_valid <= 1'b0;
            vector_addr <= mirl_pkg::VEC_SOFT_TRAP;
        end else begin
            unique case (seq)
                mirl_pkg::SEQ_IDLE: begin
                    if (instr_done) begin
                        if (soft_trap_instr) begin
                            src <= mirl_pkg::SRC_SOFT_TRAP;
                            vector_addr <= mirl_pkg::VEC_SOFT_TRAP;
                            stack_req <= 1'b1;
                            seq <= mirl_pkg::SEQ_STACK;
                        end else if (ext_req) begin
                            src <= mirl_pkg::SRC_EXTERNAL;
                            vector_addr <= mirl_pkg::VEC_EXTERNAL;
                            stack_req <= 1'b1;
                            seq <= mirl_pkg::SEQ_STACK;
                        end else if (timer_req) begin
                            src <= mirl_pkg::SRC_TIMER;
                            vector_addr <= mirl_pkg::VEC_TIMER;
                            stack_req <= 1'b1;
                            seq <= mirl_pkg::SEQ_STACK;
                        end
                    end
                end
                mirl_pkg::SEQ_STACK: begin
                    if (stack_ack) begin
                        stack_req <= 1'b0;
                        vector_valid <= 1'b1;
                        seq <= mirl_pkg::SEQ_FETCH;
                    end
                end
                mirl_pkg::SEQ_FETCH: begin
                    if (vector_ack) begin
                        vector_valid <= 1'b0;
                        seq <= mirl_pkg::SEQ_IDLE;
                    end
                end
                default: begin
                    stack_req <= 1'b0;
                    vector_valid <= 1'b0;
                    seq <= mirl_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // mask set at entry, set wins over a clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            global_mask <= mirl_pkg::GLOBAL_MASK_RESET;
        end else if (seq == mirl_pkg::SEQ_STACK && stack_ack) begin
            global_mask <= 1'b1;
        end else if (mask_clear) begin
            global_mask <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------

    // Address and data taken in either order, answer after both
    assign wr_fire = ~awready & ~wready & ~bvalid;
    assign wr_ext_int_status_control = wr_fire & aw_strb[0]
                     & (aw_idx == mirl_pkg::IDX_EXT_INT_STATUS_CONTROL);
    assign wr_option = wr_fire & aw_strb[0]
                       & (aw_idx == mirl_pkg::IDX_OPTION_REGISTER);

    // Write address channel
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awready <= 1'b1;
            aw_idx <= 6'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_idx <= awaddr[7:2];
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wready <= 1'b1;
            aw_data <= 32'h0000_0000;
            aw_strb <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            aw_data <= wdata;
            aw_strb <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // Write response, unmapped offsets answer with an error
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid <= 1'b0;
            bresp <= mirl_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            if (aw_idx == mirl_pkg::IDX_EXT_INT_STATUS_CONTROL
                || aw_idx == mirl_pkg::IDX_OPTION_REGISTER
                || aw_idx == mirl_pkg::IDX_INT_STATUS) begin
                bresp <= mirl_pkg::RESP_OKAY;
            end else begin
                bresp <= mirl_pkg::RESP_SLVERR;
            end
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // enable bit, only bit 7 of the register is storable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_int_enable <= mirl_pkg::EXT_INT_ENABLE_RESET;
        end else if (wr_ext_int_status_control) begin
            ext_int_enable <= aw_data[mirl_pkg::EXT_INT_ENABLE_BIT];
        end
    end

    // Trigger sense and port option bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_sense <= mirl_pkg::LEVEL_SENSE_RESET;
            porta_int_option <= mirl_pkg::PORTA_INT_OPTION_RESET;
        end else if (wr_option) begin
            level_sense <= aw_data[mirl_pkg::LEVEL_SENSE_BIT];
            porta_int_option <= aw_data[mirl_pkg::PORTA_INT_OPTION_BIT];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------

    // read decode, unused bits zero, clear strobe reads zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = mirl_pkg::RESP_OKAY;
        unique case (araddr[7:2])
            mirl_pkg::IDX_EXT_INT_STATUS_CONTROL: begin
                next_rdata[mirl_pkg::EXT_INT_ENABLE_BIT] = ext_int_enable;
                next_rdata[mirl_pkg::EXT_INT_PENDING_FLAG_BIT] = ext_int_pending_flag;
            end
            mirl_pkg::IDX_OPTION_REGISTER: begin
                next_rdata[mirl_pkg::LEVEL_SENSE_BIT] = level_sense;
                next_rdata[mirl_pkg::PORTA_INT_OPTION_BIT] = porta_int_option;
            end
            mirl_pkg::IDX_INT_STATUS: begin
                next_rdata[mirl_pkg::STAT_MASK_BIT] = global_mask;
                next_rdata[mirl_pkg::STAT_EXT_REQ_BIT] = ext_req;
                next_rdata[mirl_pkg::STAT_TIMER_REQ_BIT] = timer_req;
                next_rdata[mirl_pkg::STAT_SEQ_LSB +: 2] = seq;
                next_rdata[mirl_pkg::STAT_SRC_LSB +: 2] = src;
            end
            default: begin
                next_rresp = mirl_pkg::RESP_SLVERR;
            end
        endcase
    end

    // Read channels
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= mirl_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

endmodule : mirl_core

// ===== tb/mirl_sva.sv
/*
 Checker of the interrupt request logic, bound to mirl_core.
 Assumes one clock domain and the core's port names.
*/
module mirl_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Request pins
    input wire logic ext_int_pin_n,
    input wire logic [3:0] port_a_low_pins,
    // CPU sequencer side
    input wire logic instr_done,
    input wire logic soft_trap_instr,
    input wire logic stack_ack,
    input wire logic vector_ack,
    input wire logic stack_req,
    input wire logic vector_valid,
    input wire logic [15:0] vector_addr,
    input wire logic global_mask,
    input wire logic ext_int_pending_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] act_hist;
    logic idle;
    logic quiet;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Recent pin activity, covers the synchroniser delay
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            act_hist <= 4'h0;
        end else begin
            act_hist <= {act_hist[2:0], !ext_int_pin_n || (port_a_low_pins != 4'h0)};
        end
    end
    // Sequencer idle and pins quiet
    assign idle = !stack_req && !vector_valid;
    assign quiet = (act_hist == 4'h0) && ext_int_pin_n && (port_a_low_pins == 4'h0);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    boundary_only_a: assert property ($rose(stack_req) |-> $past(instr_done))
        else $error("entry started without a boundary");
    stack_hold_a: assert property (stack_req && !stack_ack |=> stack_req)
        else $error("stack request dropped early");
    fetch_masked_a: assert property ($rose(vector_valid) |-> $past(stack_ack) && global_mask)
        else $error("vector offered without stacking or mask");
    trap_vector_a: assert property (idle && instr_done && soft_trap_instr |=>
        stack_req && vector_addr == mirl_pkg::VEC_SOFT_TRAP) else $error("trap not taken");
    masked_none_a: assert property (idle && instr_done && !soft_trap_instr && global_mask |=> !stack_req)
        else $error("entry while masked");
    ext_unmasked_a: assert property ($rose(stack_req) && vector_addr == mirl_pkg::VEC_EXTERNAL |->
        !$past(global_mask)) else $error("external entry while masked");
    timer_unmasked_a: assert property ($rose(stack_req) && vector_addr == mirl_pkg::VEC_TIMER |->
        !$past(global_mask)) else $error("timer entry while masked");
    fetch_clears_a: assert property (vector_valid && vector_ack && quiet &&
        vector_addr == mirl_pkg::VEC_EXTERNAL |=> !ext_int_pending_flag) else $error("pending kept at fetch");
    pending_cause_a: assert property ($rose(ext_int_pending_flag) |-> act_hist != 4'h0)
        else $error("pending set without pin activity");
endmodule : mirl_sva

bind mirl_core mirl_sva sva (.clk, .reset_n, .ext_int_pin_n, .port_a_low_pins, .instr_done, .soft_trap_instr,
    .stack_ack, .vector_ack, .stack_req, .vector_valid, .vector_addr, .global_mask, .ext_int_pending_flag);

// ===== tb/mirl_cpu_model.sv
/*
 CPU sequencer model: acknowledges stacking and vector fetch.
 Assumes the core holds its requests until acknowledged.
*/
module mirl_cpu_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Handshake with the core
    input wire logic stack_req,
    input wire logic vector_valid,
    input wire logic [15:0] vector_addr,
    input wire logic [3:0] lat,
    output logic stack_ack,
    output logic vector_ack,
    // Record of entries
    output logic [7:0] entries,
    output logic [15:0] last_vector
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_ack <= 1'b0;
            vector_ack <= 1'b0;
            wait_cnt <= 4'h0;
            entries <= 8'h00;
            last_vector <= 16'h0000;
        end else if (stack_ack || vector_ack) begin
            stack_ack <= 1'b0;
            vector_ack <= 1'b0;
            wait_cnt <= 4'h0;
        end else if ((stack_req || vector_valid) && wait_cnt < lat) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else if (stack_req) begin
            stack_ack <= 1'b1;
        end else if (vector_valid) begin
            vector_ack <= 1'b1;
            entries <= entries + 8'h01;
            last_vector <= vector_addr;
        end
    end
endmodule : mirl_cpu_model

// ===== tb/tb_mcu_interrupt_request_logic.sv
/*
 Testbench of the interrupt request logic.
 Assumes mirl_core, the sequencer model and the bound checker.
*/
module tb_mcu_interrupt_request_logic;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset_n = 1'b0, ext_int_pin_n = 1'b1, instr_done = 1'b0, soft_trap_instr = 1'b0;
    logic mask_clear = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] port_a_low_pins = 4'h0, wstrb = 4'h1, lat = 4'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, entries;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [15:0] vector_addr, last_vector;
    logic [1:0] bresp, rresp;
    logic stack_ack, vector_ack, stack_req, vector_valid, global_mask, ext_int_pending_flag;
    logic awready, wready, bvalid, arready, rvalid;
    mirl_pkg::mirl_timer_t timer_in = 4'h0;
    int failures = 0, check_count = 0, cycles = 0;

    mirl_core dut (.clk, .reset_n, .ext_int_pin_n, .port_a_low_pins, .timer_in, .instr_done, .soft_trap_instr,
        .mask_clear, .stack_ack, .vector_ack, .stack_req, .vector_valid, .vector_addr, .global_mask,
        .ext_int_pending_flag, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    mirl_cpu_model cpu (.clk, .reset_n, .stack_req, .vector_valid, .vector_addr, .lat, .stack_ack, .vector_ack,
        .entries, .last_vector);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, mirl_pkg::RESP_OKAY});
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : axi_read
    task automatic reg_is(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check("register", d, exp);
    endtask : reg_is
    task automatic flag_is(input logic exp);
        @(negedge clk);
        check("pending", {31'h0, ext_int_pending_flag}, {31'h0, exp});
    endtask : flag_is
    task automatic pins(input logic p, input logic [3:0] q);
        @(posedge clk);
        ext_int_pin_n <= p;
        port_a_low_pins <= q;
        repeat (5) @(posedge clk);
    endtask : pins
    task automatic unmask();
        @(posedge clk);
        mask_clear <= 1'b1;
        @(posedge clk);
        mask_clear <= 1'b0;
    endtask : unmask
    // Boundary, then expect an entry with vector v when go is set
    task automatic enter(input logic trap, input logic [15:0] v, input logic go);
        logic [7:0] n0;
        n0 = entries;
        @(posedge clk);
        instr_done <= 1'b1;
        soft_trap_instr <= trap;
        @(posedge clk);
        instr_done <= 1'b0;
        soft_trap_instr <= 1'b0;
        for (int i = 0; i < 40 && entries == n0; i++) @(posedge clk);
        @(negedge clk);
        check("entries", {24'h0, entries}, {24'h0, n0 + {7'h0, go}});
        if (go) check("vector", {16'h0, last_vector}, {16'h0, v});
        if (go) check("mask", {31'h0, global_mask}, 32'h0000_0001);
        @(posedge clk);
    endtask : enter

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic scen_reset();
        logic [31:0] d;
        logic [1:0] r;
        reg_is(8'h28, 32'h0000_0080);
        axi_read(8'h3C, d, r);
        check("response", {30'h0, r}, {30'h0, mirl_pkg::RESP_SLVERR});
        axi_write(8'h28, 32'h0000_0088);
        flag_is(1'b0);
    endtask : scen_reset
    task automatic scen_edge();
        pins(1'b0, 4'h0);
        pins(1'b1, 4'h0);
        flag_is(1'b1);
        enter(1'b0, mirl_pkg::VEC_EXTERNAL, 1'b0);
        unmask();
        lat <= 4'h6;
        enter(1'b0, mirl_pkg::VEC_EXTERNAL, 1'b1);
        flag_is(1'b0);
        pins(1'b0, 4'h0);
        axi_write(8'h28, 32'h0000_0082);
        repeat (5) @(posedge clk);
        flag_is(1'b0);
        pins(1'b1, 4'h0);
        pins(1'b0, 4'h0);
        axi_write(8'h28, 32'h0000_0080);
        flag_is(1'b1);
        axi_write(8'h28, 32'h0000_0082);
        flag_is(1'b0);
        reg_is(8'h28, 32'h0000_0080);
        pins(1'b1, 4'h0);
    endtask : scen_edge
    task automatic scen_enable();
        axi_write(8'h28, 32'h0000_0000);
        pins(1'b0, 4'h0);
        pins(1'b1, 4'h0);
        unmask();
        enter(1'b0, mirl_pkg::VEC_EXTERNAL, 1'b0);
        reg_is(8'h28, 32'h0000_0008);
        axi_write(8'h28, 32'h0000_0082);
        reg_is(8'h28, 32'h0000_0080);
    endtask : scen_enable
    task automatic scen_timer();
        timer_in <= 4'b1000;
        enter(1'b0, mirl_pkg::VEC_TIMER, 1'b0);
        timer_in <= 4'b1100;
        enter(1'b0, mirl_pkg::VEC_TIMER, 1'b1);
        enter(1'b0, mirl_pkg::VEC_TIMER, 1'b0);
        enter(1'b1, mirl_pkg::VEC_SOFT_TRAP, 1'b1);
        timer_in <= 4'b0011;
        unmask();
        enter(1'b0, mirl_pkg::VEC_TIMER, 1'b1);
        pins(1'b0, 4'h0);
        pins(1'b1, 4'h0);
        unmask();
        enter(1'b0, mirl_pkg::VEC_EXTERNAL, 1'b1);
        timer_in <= 4'b0000;
    endtask : scen_timer
    task automatic scen_ports();
        pins(1'b1, 4'h1);
        flag_is(1'b0);
        pins(1'b1, 4'h0);
        axi_write(8'h5C, 32'h0000_0004);
        pins(1'b1, 4'h6);
        flag_is(1'b0);
        pins(1'b1, 4'h0);
        pins(1'b1, 4'h1);
        flag_is(1'b1);
        axi_write(8'h28, 32'h0000_0082);
        repeat (5) @(posedge clk);
        flag_is(1'b0);
        pins(1'b1, 4'h0);
        pins(1'b0, 4'h2);
        flag_is(1'b0);
        pins(1'b1, 4'h0);
        pins(1'b1, 4'h2);
        flag_is(1'b1);
        axi_write(8'h5C, 32'h0000_0006);
        axi_write(8'h28, 32'h0000_0082);
        flag_is(1'b1);
        pins(1'b1, 4'h0);
        axi_write(8'h28, 32'h0000_0082);
        pins(1'b0, 4'h0);
        axi_write(8'h28, 32'h0000_0082);
        flag_is(1'b1);
        pins(1'b1, 4'h0);
        axi_write(8'h28, 32'h0000_0082);
        flag_is(1'b0);
    endtask : scen_ports

    // Clock
    initial begin
        forever #25 clk = ~clk;
    end
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        scen_reset();
        scen_edge();
        scen_enable();
        scen_timer();
        scen_ports();
        final_report();
    end
endmodule : tb_mcu_interrupt_request_logic
